// file: src/run_mode_consts.svh
// constants for the run command mode block: codes, field widths, reset values, timing
// assumes a 25 MHz clock; frequencies are in units of 0.01 Hz
`ifndef RUN_MODE_CONSTS_SVH
`define RUN_MODE_CONSTS_SVH
`define ESC_FN_JOG 8'h01
`define SRC_KEYPAD 8'h00
`define SRC_TERMINAL 8'h01
`define FN_UP 8'h11
`define FN_DOWN 8'h12
`define FN_UD_CLEAR 8'h14
`define FN_THREE_WIRE 8'h0E
`define JOG_FREQ_MIN 16'h0032
`define JOG_FREQ_DEFAULT 16'h03E8
`define FREQ_W 16
`define TERM_N 7
`define CLK_MHZ 25
`define MIN_INPUT_US 1000
`define MIN_INPUT_CYC ((`MIN_INPUT_US) * (`CLK_MHZ))
`endif

// file: src/run_mode_pkg.sv
// types shared by the run command mode block
// assumes run_mode_consts.svh is on the include path
package run_mode_pkg;
`include "run_mode_consts.svh"
   typedef logic [`FREQ_W-1:0] freq_t;
   typedef logic [7:0] code_t;
   typedef enum logic [1:0] {
      MODE_IDLE = 2'b00,
      MODE_JOG = 2'b01,
      MODE_UPDOWN = 2'b10,
      MODE_THREE = 2'b11
   } mode_t;
   typedef enum logic [1:0] {
      RAMP_HOLD = 2'b00,
      RAMP_UP = 2'b01,
      RAMP_DOWN = 2'b10
   } ramp_t;
endpackage

// file: src/ramp_step.sv
// one-step frequency ramp toward a target, clamped to zero and a maximum
// assumes step_en is a one-cycle enable pulse from the caller's rate divider
`timescale 1ns/1ns
`include "run_mode_consts.svh"
module ramp_step (
   input wire logic clk,
   input wire logic rst,
   input wire logic step_en,
   input wire logic load,
   input wire run_mode_pkg::freq_t load_val,
   input wire run_mode_pkg::ramp_t dir,
   input wire run_mode_pkg::freq_t step,
   input wire run_mode_pkg::freq_t max_freq,
   output run_mode_pkg::freq_t freq_q
);
   import run_mode_pkg::*;
   typedef struct packed {
      freq_t f;
   } st_t;
   st_t s_q;
   st_t s_d;
   logic [`FREQ_W:0] sum;
   always_comb begin
      s_d = s_q;
      sum = {1'b0, s_q.f} + {1'b0, step};
      if (load) begin
         s_d.f = (load_val > max_freq) ? max_freq : load_val;
      end else if (step_en) begin
         case (dir)
            RAMP_UP: begin
               s_d.f = (sum > {1'b0, max_freq}) ? max_freq : sum[`FREQ_W-1:0];
            end
            RAMP_DOWN: begin
               s_d.f = (s_q.f < step) ? '0 : s_q.f - step;
            end
            default: begin
               s_d.f = s_q.f;
            end
         endcase
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign freq_q = s_q.f;
   clamp_max_a: assert property (@(posedge clk) disable iff (rst)
      freq_q <= max_freq || $past(max_freq) != max_freq) else $error("ramp above max");
endmodule

// file: src/run_command_modes.sv
// command mode logic: keypad jog, terminal up-down with saved frequency, three-wire latch
// assumes all inputs synchronous to clk; accel/decel times given as steps per tick
`timescale 1ns/1ns
`include "run_mode_consts.svh"
// Functional notes
// - keypad jog allowed only with escape function jog and keypad source
// - escape press arms jog and flashes the set lamp
// - run key while armed starts a ramp toward the jog frequency
// - releasing the run key ends jog
// - jog ramps use jog accel and jog decel times
// - terminal code up raises, code down lowers frequency
// - with run active, raise on accelerates; off holds speed
// - lower on decelerates; off holds speed
// - raise and lower together hold constant speed
// - save setting one stores frequency on run off, trip, power loss
// - restart at stored frequency on run, power return, trip recovery
// - clear terminal at constant speed erases stored frequency and state
// - terminal source with three-wire terminal latches momentary run inputs
// - forward and reverse together stop three-wire operation
// - jog frequency clamped from 0.50 Hz to max, default 10.00 Hz
module run_command_modes (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire run_mode_pkg::code_t escape_key_function_select,
   input wire run_mode_pkg::code_t run_command_source,
   input wire run_mode_pkg::code_t terminal_function_select [`TERM_N],
   input wire logic [`TERM_N-1:0] terminal_in,
   input wire logic esc_key,
   input wire logic run_key,
   input wire logic forward_run_command,
   input wire logic reverse_run_command,
   input wire logic freq_save_enable,
   input wire logic fault_trip,
   input wire logic power_loss,
   input wire run_mode_pkg::freq_t jog_freq_set,
   input wire run_mode_pkg::freq_t jog_accel_time,
   input wire run_mode_pkg::freq_t jog_decel_time,
   input wire run_mode_pkg::freq_t ud_accel_time,
   input wire run_mode_pkg::freq_t ud_decel_time,
   input wire run_mode_pkg::freq_t max_freq,
   output run_mode_pkg::freq_t out_freq,
   output logic running,
   output logic forward_dir,
   output logic set_lamp,
   output run_mode_pkg::mode_t mode,
   output run_mode_pkg::freq_t saved_freq
);
   import run_mode_pkg::*;
   // ************************************
   // helpers
   // ************************************
   function automatic logic term_any(input code_t fn, input code_t sel [`TERM_N],
                                     input logic [`TERM_N-1:0] pins);
      logic r;
      r = 1'b0;
      for (int i = 0; i < `TERM_N; i++) begin
         if (sel[i] == fn && pins[i]) begin
            r = 1'b1;
         end
      end
      return r;
   endfunction
   function automatic logic term_cfg(input code_t fn, input code_t sel [`TERM_N]);
      logic r;
      r = 1'b0;
      for (int i = 0; i < `TERM_N; i++) begin
         if (sel[i] == fn) begin
            r = 1'b1;
         end
      end
      return r;
   endfunction
   // ************************************
   // state
   // ************************************
   typedef struct packed {
      mode_t mode;
      logic armed;
      logic lamp;
      logic esc_prev;
      logic run;
      logic fwd;
      freq_t saved;
      logic saved_ok;
      logic run_prev;
      logic [15:0] fwd_cnt;
      logic [15:0] rev_cnt;
   } st_t;
   st_t s_q;
   st_t s_d;
   logic jog_ok;
   logic up_in;
   logic dn_in;
   logic clr_in;
   logic three_ok;
   logic hold_in;
   logic cmd_run;
   logic load;
   freq_t load_val;
   ramp_t dir;
   freq_t step;
   freq_t jog_tgt;
   freq_t freq;
   always_comb begin
      jog_ok = escape_key_function_select == `ESC_FN_JOG &&
               run_command_source == `SRC_KEYPAD;
      up_in = term_any(`FN_UP, terminal_function_select, terminal_in);
      dn_in = term_any(`FN_DOWN, terminal_function_select, terminal_in);
      clr_in = term_any(`FN_UD_CLEAR, terminal_function_select, terminal_in);
      three_ok = run_command_source == `SRC_TERMINAL &&
                 term_cfg(`FN_THREE_WIRE, terminal_function_select);
      hold_in = term_any(`FN_THREE_WIRE, terminal_function_select, terminal_in);
      if (jog_freq_set < `JOG_FREQ_MIN) begin
         jog_tgt = `JOG_FREQ_MIN;
      end else if (jog_freq_set > max_freq) begin
         jog_tgt = max_freq;
      end else begin
         jog_tgt = jog_freq_set;
      end
   end
   always_comb begin
      s_d = s_q;
      s_d.esc_prev = esc_key;
      load = 1'b0;
      load_val = '0;
      dir = RAMP_HOLD;
      step = '0;
      cmd_run = forward_run_command | reverse_run_command;
      // three-wire latch: a forward or reverse run press must last the minimum input time; both together stop at once
      s_d.fwd_cnt = forward_run_command ? s_q.fwd_cnt + 16'h0001 : 16'h0000;
      s_d.rev_cnt = reverse_run_command ? s_q.rev_cnt + 16'h0001 : 16'h0000;
      if (s_q.fwd_cnt == 16'hFFFF) s_d.fwd_cnt = s_q.fwd_cnt;
      if (s_q.rev_cnt == 16'hFFFF) s_d.rev_cnt = s_q.rev_cnt;
      if (three_ok) begin
         if (forward_run_command && reverse_run_command) begin
            s_d.run = 1'b0;
         end else if (!hold_in) begin
            s_d.run = 1'b0;
         end else if (s_q.fwd_cnt >= 16'(`MIN_INPUT_CYC - 1) && forward_run_command) begin
            s_d.run = 1'b1;
            s_d.fwd = 1'b1;
         end else if (s_q.rev_cnt >= 16'(`MIN_INPUT_CYC - 1) && reverse_run_command) begin
            s_d.run = 1'b1;
            s_d.fwd = 1'b0;
         end
         cmd_run = s_q.run;
      end else begin
         s_d.run = cmd_run;
         s_d.fwd = forward_run_command | !reverse_run_command;
      end
      s_d.run_prev = cmd_run & !fault_trip & !power_loss;
      // keypad jog
      if (!jog_ok) begin
         s_d.armed = 1'b0;
         s_d.lamp = 1'b0;
      end else if (esc_key && !s_q.esc_prev) begin
         s_d.armed = 1'b1;
      end
      if (s_q.armed && tick) begin
         s_d.lamp = !s_q.lamp;
      end
      if (s_q.armed && run_key) begin
         s_d.mode = MODE_JOG;
         dir = (freq < jog_tgt) ? RAMP_UP : (freq > jog_tgt) ? RAMP_DOWN : RAMP_HOLD;
         step = (dir == RAMP_UP) ? jog_accel_time : jog_decel_time;
         // snap to the target only on a tick so the last step keeps the ramp rate
         if (tick && dir == RAMP_UP && 17'(freq) + 17'(step) > 17'(jog_tgt)) begin
            load = 1'b1;
            load_val = jog_tgt;
         end else if (tick && dir == RAMP_DOWN && 17'(freq) < 17'(jog_tgt) + 17'(step)) begin
            load = 1'b1;
            load_val = jog_tgt;
         end
      end else if (s_q.mode == MODE_JOG) begin
         s_d.mode = MODE_IDLE;
         load = 1'b1;
      end else if (cmd_run && !fault_trip && !power_loss) begin
         s_d.mode = three_ok ? MODE_THREE : MODE_UPDOWN;
         if (!s_q.run_prev) begin
            load = 1'b1;
            load_val = s_q.saved_ok ? s_q.saved : '0;
         end else if (up_in && !dn_in) begin
            dir = RAMP_UP;
            step = ud_accel_time;
         end else if (dn_in && !up_in) begin
            dir = RAMP_DOWN;
            step = ud_decel_time;
         end else begin
            dir = RAMP_HOLD;
            if (clr_in) begin
               s_d.saved = '0;
               s_d.saved_ok = 1'b0;
               load = 1'b1;
            end
         end
      end else begin
         if (s_q.run_prev && freq_save_enable) begin
            s_d.saved = freq;
            s_d.saved_ok = 1'b1;
         end
         s_d.mode = MODE_IDLE;
         load = 1'b1;
      end
   end
   ramp_step u_ramp (
      .clk(clk),
      .rst(rst),
      .step_en(tick),
      .load(load),
      .load_val(load_val),
      .dir(dir),
      .step(step),
      .max_freq(max_freq),
      .freq_q(freq)
   );
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign out_freq = freq;
   assign running = s_q.mode != MODE_IDLE;
   assign forward_dir = s_q.fwd;
   assign set_lamp = s_q.lamp;
   assign mode = s_q.mode;
   assign saved_freq = s_q.saved;
   jog_gate_a: assert property (@(posedge clk) disable iff (rst)
      !jog_ok |=> !s_q.armed) else $error("jog armed while disabled");
   jog_stop_a: assert property (@(posedge clk) disable iff (rst)
      s_q.mode == MODE_JOG && !run_key |=> s_q.mode == MODE_IDLE) else $error("jog kept");
   both_hold_a: assert property (@(posedge clk) disable iff (rst)
      s_q.mode == MODE_UPDOWN && s_q.run_prev && cmd_run && up_in && dn_in && !clr_in
      && !(s_q.armed && run_key) && !fault_trip && !power_loss
      |=> $stable(freq)) else $error("ramp with both inputs");
   three_stop_a: assert property (@(posedge clk) disable iff (rst)
      three_ok && forward_run_command && reverse_run_command |=> !s_q.run)
      else $error("three-wire not stopped");
   hold_drop_a: assert property (@(posedge clk) disable iff (rst)
      three_ok && !hold_in |=> !s_q.run) else $error("latch kept");
   clr_erase_a: assert property (@(posedge clk) disable iff (rst)
      s_q.mode == MODE_UPDOWN && s_q.run_prev && cmd_run && clr_in && up_in == dn_in
      && !(s_q.armed && run_key) && !fault_trip && !power_loss
      |=> !s_q.saved_ok) else $error("clear missed");
   save_a: assert property (@(posedge clk) disable iff (rst)
      s_q.run_prev && freq_save_enable && !(s_q.armed && run_key) && s_q.mode != MODE_JOG
      && !(cmd_run && !fault_trip && !power_loss)
      |=> s_q.saved_ok && s_q.saved == $past(freq)) else $error("save missed");
   jog_range_a: assert property (@(posedge clk) disable iff (rst)
      jog_tgt >= `JOG_FREQ_MIN || max_freq < `JOG_FREQ_MIN)
      else $error("jog target low");
endmodule

// file: bench/push_panel.sv
// push-button model for the three-wire run inputs
// assumes go is a one-cycle pulse; released buttons are driven low once the hold count runs out
`timescale 1ns/1ns
module push_panel #(
   parameter int HOLD = 25100
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic go,
   input wire logic [1:0] sel,
   output logic fwd_btn,
   output logic rev_btn
);
   int cnt;
   // presses are held past the minimum input time so the latch can see them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         {fwd_btn, rev_btn} <= 2'b00;
      end else if (go) begin
         cnt <= HOLD;
         {fwd_btn, rev_btn} <= sel;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else begin
         cnt <= 0;
         {fwd_btn, rev_btn} <= 2'b00;
      end
   end
endmodule

// file: bench/run_command_modes_tb.sv
// self-checking bench for run_command_modes: jog, up-down, three-wire
// assumes the design sources and push_panel are compiled first
`timescale 1ns/1ns
`include "run_mode_consts.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
$display("mismatch %s expected %h seen %h", n, e, g); end end
module run_command_modes_tb;
   import run_mode_pkg::*;
   logic clk = 0, rst = 1, tick = 0, esc = 0, runk = 0, tfwd = 0, save = 1, go = 0, l;
   logic trip = 0, pwr = 0;
   logic [1:0] sel = 2'b00;
   logic [`TERM_N-1:0] tin = '0;
   code_t efs = `ESC_FN_JOG, src = `SRC_TERMINAL;
   code_t tfs [`TERM_N] = '{default: 8'h00};
   freq_t jf = `JOG_FREQ_DEFAULT, ja = 0, jd = 0, ua = 0, ud = 0, mx = 16'h1770, ef, tg, of, sf;
   logic run_o, dir_o, lamp, pf, pr;
   mode_t md;
   int mismatches = 0, total_checks = 0, cyc = 0, n;
   run_command_modes run_command_modes_inst (.clk(clk), .rst(rst), .tick(tick),
      .escape_key_function_select(efs), .run_command_source(src),
      .terminal_function_select(tfs), .terminal_in(tin), .esc_key(esc), .run_key(runk),
      .forward_run_command(tfwd | pf), .reverse_run_command(pr), .freq_save_enable(save),
      .fault_trip(trip), .power_loss(pwr), .jog_freq_set(jf), .jog_accel_time(ja),
      .jog_decel_time(jd), .ud_accel_time(ua), .ud_decel_time(ud), .max_freq(mx),
      .out_freq(of), .running(run_o), .forward_dir(dir_o), .set_lamp(lamp), .mode(md),
      .saved_freq(sf));
   push_panel push_panel_inst (.clk(clk), .rst(rst), .go(go), .sel(sel),
      .fwd_btn(pf), .rev_btn(pr));
   initial forever #20 clk = ~clk;
   // the three-wire presses dominate the run time
   always @(posedge clk) begin
      cyc++;
      if (cyc == 95000) begin
         mismatches++;
         summarize();
      end
   end
   function automatic freq_t up_f(freq_t f, freq_t s, freq_t m);
      return (17'(f) + 17'(s) > 17'(m)) ? m : f + s;
   endfunction
   function automatic freq_t dn_f(freq_t f, freq_t s);
      return (f > s) ? f - s : 16'h0000;
   endfunction
   task automatic step(input int k);
      repeat (k) begin
         repeat (2) @(negedge clk);
         tick = 1;
         @(negedge clk);
         tick = 0;
      end
      @(negedge clk);
   endtask
   task automatic press(input logic [1:0] s);
      sel = s;
      go = 1;
      @(negedge clk);
      go = 0;
      n = 0;
      while ((pf | pr) && n < 30000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 30000) begin
         mismatches++;
         summarize();
      end
      repeat (2) @(negedge clk);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ****************
   // main sequence
   // ****************
   initial begin
      void'($urandom(32'h58d9));
      repeat (10) @(negedge clk);
      rst = 0;
      @(negedge clk);
      `CHK("out_freq", 16'h0000, of)
      `CHK("mode", MODE_IDLE, md)
      esc = 1;
      @(negedge clk);
      runk = 1;
      repeat (3) @(negedge clk);
      `CHK("mode", MODE_IDLE, md)
      runk = 0;
      esc = 0;
      src = `SRC_KEYPAD;
      @(negedge clk);
      // second pass asks for a jog frequency below the floor
      for (int t = 0; t < 2; t++) begin
         jf = t ? 16'h0010 : 16'($urandom_range(3000, 100));
         ja = 16'($urandom_range(400, 20));
         tg = (jf < `JOG_FREQ_MIN) ? `JOG_FREQ_MIN : jf;
         esc = 1;
         repeat (2) @(negedge clk);
         l = lamp;
         step(1);
         `CHK("set_lamp", ~l, lamp)
         runk = 1;
         repeat (2) @(negedge clk);
         `CHK("mode", MODE_JOG, md)
         ef = 16'h0000;
         step(2);
         repeat (2) ef = up_f(ef, ja, tg);
         `CHK("out_freq", ef, of)
         step(tg / ja + 2);
         `CHK("out_freq", tg, of)
         // lowering the target mid-jog must ramp with the decel step
         jd = ja + 16'($urandom_range(200, 1));
         ef = dn_f(tg, jd);
         jf = tg / 2;
         tg = (jf < `JOG_FREQ_MIN) ? `JOG_FREQ_MIN : jf;
         if (ef < tg) ef = tg;
         step(1);
         `CHK("out_freq", ef, of)
         runk = 0;
         esc = 0;
         repeat (2) @(negedge clk);
         `CHK("mode", MODE_IDLE, md)
         `CHK("out_freq", 16'h0000, of)
      end
      $display("test jog done");
      src = `SRC_TERMINAL;
      tfs[0] = `FN_UP;
      tfs[1] = `FN_DOWN;
      tfs[2] = `FN_UD_CLEAR;
      tfwd = 1;
      repeat (2) @(negedge clk);
      `CHK("mode", MODE_UPDOWN, md)
      ef = 16'h0000;
      ua = 16'($urandom_range(500, 1));
      n = $urandom_range(6, 2);
      tin[0] = 1;
      step(n);
      repeat (n) ef = up_f(ef, ua, mx);
      `CHK("out_freq", ef, of)
      tin[0] = 0;
      step(2);
      `CHK("out_freq", ef, of)
      ua = 16'h0FFF;
      tin[0] = 1;
      step(3);
      repeat (3) ef = up_f(ef, ua, mx);
      `CHK("out_freq", ef, of)
      ud = 16'($urandom_range(900, 1));
      tin[0] = 0;
      tin[1] = 1;
      step(n);
      repeat (n) ef = dn_f(ef, ud);
      `CHK("out_freq", ef, of)
      tin[0] = 1;
      step(2);
      `CHK("out_freq", ef, of)
      tin = '0;
      tfwd = 0;
      repeat (2) @(negedge clk);
      `CHK("saved_freq", ef, sf)
      tfwd = 1;
      repeat (2) @(negedge clk);
      `CHK("out_freq", ef, of)
      // a trip, then a power loss: each saves the live frequency, recovery restores it
      for (int k = 0; k < 2; k++) begin
         tin[k] = 1;
         step(1);
         tin[k] = 0;
         ef = k ? dn_f(ef, ud) : up_f(ef, ua, mx);
         {pwr, trip} = k ? 2'b10 : 2'b01;
         repeat (2) @(negedge clk);
         `CHK("saved_freq", ef, sf)
         {pwr, trip} = 2'b00;
         repeat (2) @(negedge clk);
         `CHK("out_freq", ef, of)
      end
      // with saving off a stop must leave the stored value alone
      tin[0] = 1;
      step(1);
      tin[0] = 0;
      save = 0;
      tfwd = 0;
      repeat (2) @(negedge clk);
      `CHK("saved_freq", ef, sf)
      save = 1;
      tfwd = 1;
      repeat (2) @(negedge clk);
      `CHK("out_freq", ef, of)
      tin[2] = 1;
      repeat (2) @(negedge clk);
      `CHK("saved_freq", 16'h0000, sf)
      tin[2] = 0;
      tfwd = 0;
      repeat (2) @(negedge clk);
      $display("test up-down done");
      tfs[3] = `FN_THREE_WIRE;
      tin[3] = 1;
      @(negedge clk);
      press(2'b10);
      `CHK("running", 1'b1, run_o)
      `CHK("mode", MODE_THREE, md)
      `CHK("forward_dir", 1'b1, dir_o)
      tin[3] = 0;
      repeat (2) @(negedge clk);
      `CHK("running", 1'b0, run_o)
      tin[3] = 1;
      // a press far shorter than the minimum input time must not latch
      tfwd = 1;
      repeat (100) @(negedge clk);
      tfwd = 0;
      repeat (2) @(negedge clk);
      `CHK("running", 1'b0, run_o)
      press(2'b01);
      `CHK("running", 1'b1, run_o)
      `CHK("forward_dir", 1'b0, dir_o)
      press(2'b11);
      `CHK("running", 1'b0, run_o)
      $display("test three-wire done");
      summarize();
   end
endmodule
